/* bitwise_exec_pkg.sv */
//----------------------------------------------------------------------------
// bitwise_exec_pkg
//----------------------------------------------------------------------------
// Purpose: constants, field layouts and carriers for the bitwise execute block
// Assumes: a 16-bit instruction sits in word[15:0]; a 32-bit one has its
//          first halfword in word[31:16] and its second in word[15:0]
// Notes:   register window: r0..r15 at 0x00..0x0f, flags, status
//----------------------------------------------------------------------------
package bitwise_exec_pkg;

  // --------------------------------------------------------------------------
  // register window
  // --------------------------------------------------------------------------
  localparam logic [7:0]  REG_LAST_ADDR   = 8'h0f;
  localparam logic [7:0]  FLAGS_ADDR      = 8'h10;
  localparam logic [7:0]  STATUS_ADDR     = 8'h11;
  localparam int          FLAGS_LSB       = 28;
  localparam logic [3:0]  FLAGS_RESET     = 4'h0;
  localparam logic [31:0] REG_RESET       = 32'h0000_0000;
  // status fields
  localparam int          ST_UNPRED_BIT   = 0;
  localparam int          ST_FOREIGN_BIT  = 1;
  localparam int          ST_CLASS_LSB    = 2;
  localparam int          ST_COUNT_LSB    = 16;
  // flag positions inside the 4-bit flag vector
  localparam int          FLAG_N          = 3;
  localparam int          FLAG_Z          = 2;
  localparam int          FLAG_C          = 1;
  localparam int          FLAG_V          = 0;

  // --------------------------------------------------------------------------
  // opcode patterns (mask, value)
  // --------------------------------------------------------------------------
  localparam logic [15:0] INV16_MASK      = 16'hffc0;
  localparam logic [15:0] INV16_VAL       = 16'h43c0;
  localparam logic [15:0] NEG16_MASK      = 16'hffc0;
  localparam logic [15:0] NEG16_VAL       = 16'h4240;
  localparam logic [15:0] NOP16_VAL       = 16'hbf00;
  localparam logic [31:0] INV32_MASK      = 32'hffef_8000;
  localparam logic [31:0] INV32_VAL       = 32'hea6f_0000;
  localparam logic [31:0] ORNI_MASK       = 32'hfbe0_8000;
  localparam logic [31:0] ORNI_VAL        = 32'hf060_0000;
  localparam logic [31:0] NOP32_MASK      = 32'hfff0_d7ff;
  localparam logic [31:0] NOP32_VAL       = 32'hf3a0_8000;
  localparam logic [3:0]  ALL_ONES_REG    = 4'hf;
  localparam logic [3:0]  SP_REG          = 4'hd;
  localparam logic [3:0]  PC_REG          = 4'hf;

  // --------------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {SH_LSL, SH_LSR, SH_ASR, SH_ROR} shift_type_t;

  typedef enum logic [2:0] {
    CLS_NONE, CLS_INV16, CLS_INV32, CLS_INV_IMM, CLS_ORN_IMM, CLS_NEG, CLS_NOP
  } op_class_t;

  typedef struct packed {
    logic        valid;
    logic        wide;
    logic        cond_pass;
    logic        in_cond_block;
    logic [31:0] word;
  } instr_req_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } reg_bus_req_t;

  typedef struct packed {
    logic        done;
    logic        unpredictable;
    logic        foreign;
    logic        wrote;
  } exec_status_t;

endpackage : bitwise_exec_pkg

/* shift_expand_unit.sv */
//----------------------------------------------------------------------------
// Purpose: register shifter with carry and modified-immediate expander
// Assumes: purely combinational; carry_in is the current carry flag
// Notes:   expand_sel picks the expander, else the shifter drives result
//----------------------------------------------------------------------------
module shift_expand_unit
  import bitwise_exec_pkg::*;
(
  input  wire logic                          expand_sel,
  input  wire logic [31:0]                   value,
  input  wire bitwise_exec_pkg::shift_type_t stype,
  input  wire logic [4:0]                    imm5,
  input  wire logic [11:0]                   imm12,
  input  wire logic                          carry_in,
  output logic      [31:0]                   result,
  output logic                               carry_out
);

  logic [32:0] ext;
  logic [5:0]  amt;
  logic [31:0] unrot;
  logic [7:0]  b;

  always_comb begin
    ext       = 33'h0_0000_0000;
    result    = value;
    carry_out = carry_in;
    b         = imm12[7:0];
    unrot     = {24'h00_0000, 1'b1, imm12[6:0]};
    // lsr/asr with a zero field mean a shift by 32
    amt       = (imm5 == 5'h00) ? 6'h20 : {1'b0, imm5};
    if (expand_sel) begin
      if (imm12[11:10] == 2'h0) begin
        // replicated byte forms keep the incoming carry
        case (imm12[9:8])
          2'h0:    result = {24'h00_0000, b};
          2'h1:    result = {8'h00, b, 8'h00, b};
          2'h2:    result = {b, 8'h00, b, 8'h00};
          default: result = {b, b, b, b};
        endcase
      end else begin
        result    = (unrot >> imm12[11:7]) | (unrot << (6'h20 - {1'b0, imm12[11:7]}));
        carry_out = result[31];
      end
    end else begin
      case (stype)
        SH_LSL: begin
          if (imm5 != 5'h00) begin
            ext       = {1'b0, value} << imm5;
            result    = ext[31:0];
            carry_out = ext[32];
          end
        end
        SH_LSR: begin
          ext       = {value, 1'b0} >> amt;
          result    = ext[32:1];
          carry_out = ext[0];
        end
        SH_ASR: begin
          ext       = 33'($signed({value, 1'b0}) >>> amt);
          result    = ext[32:1];
          carry_out = ext[0];
        end
        default: begin
          if (imm5 == 5'h00) begin
            // rotate through carry by one
            result    = {carry_in, value[31:1]};
            carry_out = value[0];
          end else begin
            result    = (value >> imm5) | (value << (6'h20 - {1'b0, imm5}));
            carry_out = result[31];
          end
        end
      endcase
    end
  end

endmodule : shift_expand_unit

/* bitwise_exec.sv */
//----------------------------------------------------------------------------
// Purpose: decode and single-cycle execute of the inverse-move, zero-minus,
//          no-operation and or-with-complement group
// Assumes: the issuing pipeline supplies condition-pass and conditional-block
//          status with each instruction
// Notes:   holds its own 16-entry register file and flags, reachable over a
//          plain register port; unpredictable encodings write nothing
//----------------------------------------------------------------------------
module bitwise_exec
  import bitwise_exec_pkg::*;
(
  input  wire logic                           sys_clk,
  input  wire logic                           rstn,
  input  wire bitwise_exec_pkg::instr_req_t   instr,
  input  wire bitwise_exec_pkg::reg_bus_req_t bus,
  output logic      [31:0]                    bus_rdata,
  output bitwise_exec_pkg::exec_status_t      status,
  output logic      [3:0]                     flags
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [15:0][31:0] regs;
    logic [3:0]        flags;
    logic [31:0]       rdata;
    exec_status_t      st;
    op_class_t         last_cls;
    logic              last_unpred;
    logic              last_foreign;
    logic [15:0]       count;
  } state_t;

  typedef struct packed {
    op_class_t   cls;
    logic [3:0]  rd;
    logic [3:0]  src;
    logic [3:0]  opnd;
    logic        setflags;
    logic        expand;
    shift_type_t stype;
    logic [4:0]  imm5;
    logic [11:0] imm12;
    logic        unpred;
  } decode_t;

  state_t      st_q;
  state_t      st_d;
  decode_t     dec;
  logic [15:0] hw1;
  logic [15:0] lo;
  logic [31:0] sx_value;
  logic [31:0] sx_result;
  logic        sx_carry;

  assign hw1 = instr.word[31:16];
  assign lo  = instr.word[15:0];

  // --------------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------------
  always_comb begin
    dec          = '0;
    dec.cls      = CLS_NONE;
    dec.stype    = SH_LSL;
    if (!instr.wide) begin
      if ((lo & INV16_MASK) == INV16_VAL) begin
        dec.cls      = CLS_INV16;
        dec.rd       = {1'b0, lo[2:0]};
        dec.src      = {1'b0, lo[5:3]};
        dec.setflags = !instr.in_cond_block;
        dec.imm5     = 5'h00;
      end else if ((lo & NEG16_MASK) == NEG16_VAL) begin
        dec.cls      = CLS_NEG;
        dec.rd       = {1'b0, lo[2:0]};
        dec.src      = {1'b0, lo[5:3]};
        dec.setflags = 1'b1;
      end else if (lo == NOP16_VAL) begin
        dec.cls      = CLS_NOP;
      end
    end else begin
      if ((instr.word & INV32_MASK) == INV32_VAL) begin
        dec.cls      = CLS_INV32;
        dec.rd       = lo[11:8];
        dec.src      = lo[3:0];
        dec.setflags = hw1[4];
        dec.stype    = shift_type_t'(lo[5:4]);
        dec.imm5     = {lo[14:12], lo[7:6]};
        dec.unpred   = (dec.rd == SP_REG) || (dec.rd == PC_REG) ||
                       (dec.src == SP_REG) || (dec.src == PC_REG);
      end else if ((instr.word & ORNI_MASK) == ORNI_VAL) begin
        dec.rd       = lo[11:8];
        dec.opnd     = hw1[3:0];
        dec.setflags = (hw1[4] == 1'b1);
        dec.expand   = 1'b1;
        dec.imm12    = {hw1[10], lo[14:12], lo[7:0]};
        if (dec.opnd == ALL_ONES_REG) begin
          dec.cls    = CLS_INV_IMM;
          dec.unpred = (dec.rd == SP_REG) || (dec.rd == PC_REG);
        end else begin
          dec.cls    = CLS_ORN_IMM;
          dec.unpred = (dec.rd == SP_REG) || (dec.rd == PC_REG) ||
                       (dec.opnd == SP_REG);
        end
      end else if ((instr.word & NOP32_MASK) == NOP32_VAL) begin
        dec.cls      = CLS_NOP;
      end
    end
  end

  // shifter always sees the carry flag as its carry in
  assign sx_value = st_q.regs[dec.src];

  shift_expand_unit u_shift_expand (
    .expand_sel (dec.expand),
    .value      (sx_value),
    .stype      (dec.stype),
    .imm5       (dec.imm5),
    .imm12      (dec.imm12),
    .carry_in   (st_q.flags[FLAG_C]),
    .result     (sx_result),
    .carry_out  (sx_carry)
  );

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic [31:0] res;
    logic [32:0] neg_sum;
    logic        carry;
    logic        ovf;
    logic        write_en;
    res      = 32'h0000_0000;
    neg_sum  = 33'h0_0000_0000;
    carry    = st_q.flags[FLAG_C];
    ovf      = st_q.flags[FLAG_V];
    write_en = 1'b0;
    st_d     = st_q;
    st_d.st  = '0;
    st_d.rdata = 32'h0000_0000;

    // register port: bus writes land first so an instruction in the same
    // cycle sees its own result win on a shared register
    if (bus.wr) begin
      if (bus.addr <= REG_LAST_ADDR) begin
        st_d.regs[bus.addr[3:0]] = bus.wdata;
      end else if (bus.addr == FLAGS_ADDR) begin
        st_d.flags = bus.wdata[FLAGS_LSB +: 4];
      end else if (bus.addr == STATUS_ADDR) begin
        st_d.count = 16'h0000;
      end
    end
    if (bus.rd) begin
      if (bus.addr <= REG_LAST_ADDR) begin
        st_d.rdata = st_q.regs[bus.addr[3:0]];
      end else if (bus.addr == FLAGS_ADDR) begin
        st_d.rdata[FLAGS_LSB +: 4] = st_q.flags;
      end else if (bus.addr == STATUS_ADDR) begin
        st_d.rdata[ST_UNPRED_BIT]        = st_q.last_unpred;
        st_d.rdata[ST_FOREIGN_BIT]       = st_q.last_foreign;
        st_d.rdata[ST_CLASS_LSB +: 3]    = st_q.last_cls;
        st_d.rdata[ST_COUNT_LSB +: 16]   = st_q.count;
      end
    end

    // execute
    case (dec.cls)
      CLS_INV16, CLS_INV32: begin
        res      = ~sx_result;
        carry    = sx_carry;
        write_en = 1'b1;
      end
      CLS_INV_IMM: begin
        res      = ~sx_result;
        carry    = sx_carry;
        write_en = 1'b1;
      end
      CLS_ORN_IMM: begin
        res      = st_q.regs[dec.opnd] | ~sx_result;
        carry    = sx_carry;
        write_en = 1'b1;
      end
      CLS_NEG: begin
        // zero minus source: not(src) + 0 + 1
        neg_sum  = {1'b0, ~sx_value} + 33'h0_0000_0001;
        res      = neg_sum[31:0];
        carry    = neg_sum[32];
        ovf      = sx_value[31] & neg_sum[31];
        write_en = 1'b1;
      end
      default: begin
        write_en = 1'b0;
      end
    endcase

    if (instr.valid) begin
      st_d.st.done    = 1'b1;
      st_d.st.foreign = (dec.cls == CLS_NONE);
      st_d.last_cls   = dec.cls;
      st_d.last_unpred  = dec.unpred;
      st_d.last_foreign = (dec.cls == CLS_NONE);
      if (dec.cls != CLS_NONE) begin
        st_d.count = st_q.count + 16'h0001;
      end
      // failed condition or unpredictable encoding: no architectural change
      if (instr.cond_pass && !dec.unpred && write_en) begin
        st_d.regs[dec.rd] = res;
        st_d.st.wrote     = 1'b1;
        if (dec.setflags) begin
          st_d.flags[FLAG_N] = res[31];
          st_d.flags[FLAG_Z] = (res == 32'h0000_0000);
          st_d.flags[FLAG_C] = carry;
          st_d.flags[FLAG_V] = ovf;
        end
      end
      st_d.st.unpredictable = dec.unpred;
    end
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_q              <= '0;
      st_q.regs         <= {16{REG_RESET}};
      st_q.flags        <= FLAGS_RESET;
      st_q.last_cls     <= CLS_NONE;
    end else begin
      st_q <= st_d;
    end
  end

  assign bus_rdata = st_q.rdata;
  assign status    = st_q.st;
  assign flags     = st_q.flags;

endmodule : bitwise_exec

/* bitwise_exec_sva.sv */
//----------------------------------------------------------------------------
// Purpose: port-level checks of the bitwise execute block
// Assumes: synchronous active-low reset, results one cycle after the take
// Notes:   bus writes to the flag word are excluded where flags must hold
//----------------------------------------------------------------------------
module bitwise_exec_sva
  import bitwise_exec_pkg::*;
(
  input wire logic                           sys_clk,
  input wire logic                           rstn,
  input wire bitwise_exec_pkg::instr_req_t   instr,
  input wire bitwise_exec_pkg::reg_bus_req_t bus,
  input wire logic [31:0]                    bus_rdata,
  input wire bitwise_exec_pkg::exec_status_t status,
  input wire logic [3:0]                     flags
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // --------------------------------------------------------------------------
  // decode helpers
  // --------------------------------------------------------------------------
  logic       go;
  logic       fw;
  logic       inv16;
  logic       inv32;
  logic       orni;
  logic       c_f;
  logic       v_f;
  logic [3:0] dst_f;
  logic [3:0] src_f;
  logic [3:0] opnd_f;
  assign go     = instr.valid && instr.cond_pass;
  // a bus write to the flag word may legally move flags in the same cycle
  assign fw     = bus.wr && bus.addr == FLAGS_ADDR;
  assign inv16  = !instr.wide && (instr.word[15:0] & INV16_MASK) == INV16_VAL;
  assign inv32  = instr.wide && (instr.word & INV32_MASK) == INV32_VAL;
  assign orni   = instr.wide && (instr.word & ORNI_MASK) == ORNI_VAL;
  assign c_f    = flags[FLAG_C];
  assign v_f    = flags[FLAG_V];
  assign dst_f  = instr.word[11:8];
  assign src_f  = instr.word[3:0];
  assign opnd_f = instr.word[19:16];

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  a_done_follows: assert property (instr.valid |=> status.done)
    else $error("done missing after an instruction");
  a_fail_quiet: assert property (instr.valid && !instr.cond_pass && !fw |=>
    !status.wrote && $stable(flags)) else $error("failed condition had effect");
  a_block_no_flags: assert property (go && inv16 && instr.in_cond_block && !fw |=>
    $stable(flags) && status.wrote) else $error("short inverse in block moved flags");
  a_carry_kept: assert property (go && inv16 && !fw |=> $stable(c_f) && $stable(v_f))
    else $error("short inverse changed carry or overflow");
  a_ovf_kept: assert property (go && (inv32 || orni) && !fw |=> $stable(v_f))
    else $error("overflow flag changed");
  a_wide_unpred: assert property (go && inv32 && (dst_f == 4'hd || dst_f == 4'hf ||
    src_f == 4'hd || src_f == 4'hf) |=> status.unpredictable && !status.wrote)
    else $error("wide inverse with sp or pc not refused");
  a_opnd_unpred: assert property (go && orni && opnd_f != 4'hf &&
    (dst_f == 4'hd || dst_f == 4'hf || opnd_f == 4'hd) |=> status.unpredictable && !status.wrote)
    else $error("or-complement with sp or pc not refused");
  a_hint_short: assert property (go && !instr.wide && !fw &&
    instr.word[15:0] == NOP16_VAL |=> !status.wrote && !status.foreign && $stable(flags))
    else $error("short hint had effect");
  a_hint_wide: assert property (go && instr.wide && !fw &&
    (instr.word & NOP32_MASK) == NOP32_VAL |=> !status.wrote && !status.foreign && $stable(flags))
    else $error("wide hint had effect");
  a_rdata_idle: assert property (!bus.rd |=> bus_rdata == 32'h0)
    else $error("read data outside the answer cycle");

  c_wide_exec: cover property (go && inv32);
  c_orni_exec: cover property (go && orni);
  c_cond_fail: cover property (instr.valid && !instr.cond_pass);
endmodule : bitwise_exec_sva

bind bitwise_exec bitwise_exec_sva bitwise_exec_sva_i (
  .sys_clk   (sys_clk),
  .rstn      (rstn),
  .instr     (instr),
  .bus       (bus),
  .bus_rdata (bus_rdata),
  .status    (status),
  .flags     (flags)
);

/* testbench.sv */
//----------------------------------------------------------------------------
// Purpose: corner and random stimulus for bitwise_exec
// Assumes: status and flags settle one cycle after the taking edge
// Notes:   a shadow register file predicts every result
//----------------------------------------------------------------------------
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import bitwise_exec_pkg::*;

  logic         sys_clk  = 1'b0;
  logic         rstn     = 1'b0;
  instr_req_t   instr    = '0;
  reg_bus_req_t bus      = '0;
  logic [31:0]  bus_rdata;
  exec_status_t status;
  logic [3:0]   flags;
  logic [31:0]  m_reg [16];
  logic [3:0]   m_flags  = 4'h0;
  logic [31:0]  seed     = 32'h0000_1c5f;
  int           n_fail   = 0;
  int           n_checks = 0;
  // wide bit on top; the unknown word stays last so the failing pass can skip it
  logic [32:0]  cw [13] = '{33'h0_0000_43c8, 33'h0_0000_4254, 33'h0_0000_425d,
    33'h1_ea7f_0011, 33'h1_ea7f_0632, 33'h1_ea6f_0d01, 33'h1_ea6f_010f, 33'h1_f06d_0100,
    33'h1_f47f_7155, 33'h1_f071_32ab, 33'h1_f3af_8000, 33'h0_0000_bf00, 33'h0_0000_0000};

  always #5 sys_clk = ~sys_clk;

  bitwise_exec bitwise_exec_i (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .instr     (instr),
    .bus       (bus),
    .bus_rdata (bus_rdata),
    .status    (status),
    .flags     (flags)
  );

  // --------------------------------------------------------------------------
  // reference functions
  // --------------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [32:0] shift_c(logic [31:0] v, logic [1:0] t, logic [4:0] n,
                                          logic c);
    logic [31:0] r;
    r = (v >> n) | (v << (32 - n));
    case (t)
      2'h0: return (n == 0) ? {c, v} : {v[32 - n], v << n};
      2'h1: return (n == 0) ? {v[31], 32'h0} : {v[n - 1], v >> n};
      2'h2: return (n == 0) ? {v[31], {32{v[31]}}} : {v[n - 1], 32'($signed(v) >>> n)};
      default: return (n == 0) ? {v[0], c, v[31:1]} : {r[31], r};
    endcase
  endfunction : shift_c

  function automatic logic [32:0] expand(logic [11:0] m, logic c);
    logic [7:0] b;
    b = m[7:0];
    if (m[11:10] != 2'h0) return shift_c({24'h0, 1'b1, m[6:0]}, 2'h3, m[11:7], c);
    case (m[9:8])
      2'h0: return {c, 24'h0, b};
      2'h1: return {c, 8'h0, b, 8'h0, b};
      2'h2: return {c, b, 8'h0, b, 8'h0};
      default: return {c, b, b, b, b};
    endcase
  endfunction : expand

  // --------------------------------------------------------------------------
  // compares, bus cycles and the shadow model
  // --------------------------------------------------------------------------
  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk32

  task automatic chk4(input string nm, input logic [3:0] e, input logic [3:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk4

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
    if (a <= REG_LAST_ADDR) m_reg[a[3:0]] = v;
    if (a == FLAGS_ADDR) m_flags = v[31:28];
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1 chk32("bus_rdata", e, bus_rdata);
  endtask : rd

  task automatic model(input logic w, input logic [31:0] x, input logic cp, input logic ib,
                       output logic [3:0] st, output logic [3:0] d);
    logic [32:0] r;
    logic [32:0] e;
    logic [3:0]  n;
    logic        s;
    logic        v;
    logic        up;
    int          k;
    s = 1'b0;
    up = 1'b0;
    k = 1;
    r = '0;
    v = m_flags[FLAG_V];
    d = x[11:8];
    n = x[19:16];
    if (!w && (x[15:0] & INV16_MASK) == INV16_VAL) begin
      d = {1'b0, x[2:0]};
      r = {m_flags[FLAG_C], ~m_reg[x[5:3]]};
      s = !ib;
    end else if (!w && (x[15:0] & NEG16_MASK) == NEG16_VAL) begin
      d = {1'b0, x[2:0]};
      r = {m_reg[x[5:3]] == 32'h0, 32'h0 - m_reg[x[5:3]]};
      s = 1'b1;
      v = m_reg[x[5:3]] == 32'h8000_0000;
    end else if (w && (x & INV32_MASK) == INV32_VAL) begin
      e = shift_c(m_reg[x[3:0]], x[5:4], {x[14:12], x[7:6]}, m_flags[FLAG_C]);
      r = {e[32], ~e[31:0]};
      s = x[20];
      up = d == 4'hd || d == 4'hf || x[3:0] == 4'hd || x[3:0] == 4'hf;
    end else if (w && (x & ORNI_MASK) == ORNI_VAL) begin
      e = expand({x[26], x[14:12], x[7:0]}, m_flags[FLAG_C]);
      r = {e[32], (n == 4'hf ? 32'h0 : m_reg[n]) | ~e[31:0]};
      s = x[20];
      up = d == 4'hd || d == 4'hf || n == 4'hd;
    end else if ((!w && x[15:0] == NOP16_VAL) || (w && (x & NOP32_MASK) == NOP32_VAL)) begin
      k = 0;
    end else begin
      k = 2;
    end
    // the unpredictable mark reports the encoding, whatever the condition
    st = {1'b1, up, k == 2, 1'b0};
    // a failed condition leaves the shadow untouched
    if (k == 1 && cp && !up) begin
      m_reg[d] = r[31:0];
      st[0] = 1'b1;
      if (s) m_flags = {r[31], r[31:0] == 32'h0, r[32], v};
    end
  endtask : model

  task automatic run(input logic w, input logic [31:0] x, input logic cp, input logic ib);
    logic [3:0] st;
    logic [3:0] d;
    model(w, x, cp, ib, st, d);
    @(posedge sys_clk);
    instr <= '{valid: 1'b1, wide: w, cond_pass: cp, in_cond_block: ib, word: x};
    @(posedge sys_clk);
    instr.valid <= 1'b0;
    #1 chk4("status", st, status);
    chk4("flags", m_flags, flags);
    rd({4'h0, d}, m_reg[d]);
  endtask : run

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  // --------------------------------------------------------------------------
  // sequence
  // --------------------------------------------------------------------------
  initial begin
    repeat (50000) @(posedge sys_clk);
    n_fail++;
    $display("ERROR watchdog expected finish seen hang");
    results();
  end

  initial begin
    logic [31:0] x;
    logic [31:0] q;
    foreach (m_reg[i]) m_reg[i] = 32'h0;
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    for (int a = 0; a < 19; a++) rd(8'(a), 32'h0);
    wr(8'h20, 32'hffff_ffff);
    rd(8'h20, 32'h0);
    $display("test reset_map done");
    for (int a = 0; a < 16; a++) wr(8'(a), rnd());
    wr(8'h01, 32'hffff_ffff);
    wr(8'h02, 32'h8000_0000);
    wr(8'h03, 32'h0);
    wr(FLAGS_ADDR, 32'h2000_0000);
    rd(FLAGS_ADDR, 32'h2000_0000);
    // pass 0 plain, pass 1 inside a conditional block, pass 2 condition failed
    for (int p = 0; p < 3; p++) begin
      for (int c = 0; c < 13 - (p == 2); c++) begin
        run(cw[c][32], cw[c][31:0], p != 2, p == 1);
      end
    end
    // status word: last class no-operation (6), 36 in-group words counted, then cleared
    rd(STATUS_ADDR, 32'h0024_0018);
    wr(STATUS_ADDR, 32'h0);
    rd(STATUS_ADDR, 32'h0000_0018);
    $display("test corners done");
    for (int i = 0; i < 400; i++) begin
      x = rnd();
      q = rnd();
      if (i % 50 == 0) wr(FLAGS_ADDR, rnd());
      case (x % 6)
        0: run(1'b0, {16'h0, INV16_VAL | 16'(q[5:0])}, q[30:29] != 0, q[31]);
        1: run(1'b0, {16'h0, NEG16_VAL | 16'(q[5:0])}, q[30:29] != 0, q[31]);
        2: run(1'b1, INV32_VAL | {11'h0, q[20], 5'h0, q[14:12], 4'(x[31:8] % 13),
               q[7:4], 4'(x[30:4] % 13)}, q[30:29] != 0, q[31]);
        3: run(1'b1, ORNI_VAL | {5'h0, q[26], 5'h0, q[20],
               q[24] ? 4'hf : 4'(x[20:8] % 13), 1'b0, q[14:12], 4'(x[31:9] % 13), q[7:0]},
               q[30:29] != 0, q[31]);
        4: run(1'b0, {16'h0, NOP16_VAL}, q[30:29] != 0, q[31]);
        default: run(1'b1, NOP32_VAL | (q & ~NOP32_MASK), q[30:29] != 0, q[31]);
      endcase
    end
    $display("test random done");
    results();
  end
endmodule : testbench
